/* mdep_cfg.svh */
`ifndef MDEP_CFG_SVH
`define MDEP_CFG_SVH

`define MDEP_ADDR_ENC_ADJUST  16'h052c
`define MDEP_ADDR_DIR_INV     16'h0618
`define MDEP_ADDR_ENC_ABS_POS 16'h1e1e

`define MDEP_DIR_INV_RST      1'b0
`define MDEP_DIR_INV_OFF      1'b0
`define MDEP_DIR_INV_ON       1'b1
`define MDEP_DIR_INV_BIT      0
`define MDEP_SHIFT_OFF        1'b0

`define MDEP_ADJUST_RST       32'h0000_0000

`define MDEP_ENC_INC_PER_TURN 32'h0002_0000
`define MDEP_ENC_TURNS        32'h0000_1000
`define MDEP_ENC_HALF_TURNS   32'h0000_0800
`define MDEP_USR_PER_TURN     32'h0000_4000
`define MDEP_INC_TO_USR_SHIFT 3

`endif

/* mdep_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdep_enc_model #(
    parameter int LAT = 3
) (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        encRdReq,
    input wire logic [31:0] rawPos,
    output logic            encRdValid,
    output logic [31:0]     encRdRaw
);
    logic [3:0] cnt;
    // Answers a read some cycles later, shows the inverted position otherwise
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) cnt <= 4'h0;
        else if (encRdReq) cnt <= 4'(LAT);
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    assign encRdValid = (cnt == 4'h1);
    assign encRdRaw   = encRdValid ? rawPos : ~rawPos;
endmodule
`default_nettype wire

/* mdep_motion_position.sv */
`timescale 1ns/1ps
`default_nettype none

`include "mdep_cfg.svh"

// Functional notes
// R1: A positive or negative jog-with-enable input enables the power stage and jogs that way.
// R2: Direction inversion 0 keeps target sign, 1 makes negative targets move positive.
// R3: Inversion setting is writable only with the power stage off, resets off, applies at power-on.
// R4: At start-up the encoder absolute position is read before it becomes the position reference.
// R5: A read-only 32-bit value gives the absolute position modulo the encoder range.
// R6: The singleturn range is 131072 increments per turn.
// R7: The multiturn range is 4096 turns of 131072 increments.
// R8: Below absolute zero the actual position keeps counting and goes negative.
// R9: After a power cycle the actual position restarts from the encoder absolute position.
// R10: The absolute position may be rewritten only at standstill, naming the present shaft place.
// R11: An adjustment shifts the index pulse by the same offset.
// R12: Adjustment limits depend on encoder type and on whether the range is shifted.
// R13: One turn spans x = 16384 user units by default.
// R14: The controller sets inversion before adjusting when inverted operation is wanted.
// R15: The controller waits one second after an adjustment before removing power.
// R16: The controller should place the negative mechanical limit above zero.
// R17: Working range shift, when on, centres the multiturn range on zero.
module mdep_motion_position
    import mdep_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        parWrEn,
    input  wire logic        parRdEn,
    input  wire logic [15:0] parAddr,
    input  wire logic [31:0] parWrData,
    output logic [31:0]      parRdData,
    output logic             parAck,
    output logic             parErr,
    input  wire logic        jogPosPin,
    input  wire logic        jogNegPin,
    input  wire logic        hostEnable,
    input  wire logic        motStandstill,
    output logic             pwrStageOn,
    output logic             jogActive,
    output logic             jogDirNeg,
    input  wire logic        cmdValid,
    input  wire mdep_pos_t   cmdTarget,
    output logic             motValid,
    output mdep_pos_t        motTarget,
    input  wire logic        bootDirInv,
    input  wire logic        bootShift,
    input  wire logic        encMultiturn,
    output logic             encRdReq,
    input  wire logic        encRdValid,
    input  wire logic [31:0] encRdRaw,
    input  wire logic        encDeltaValid,
    input  wire mdep_pos_t   encDelta,
    output logic             encAdjStb,
    output mdep_pos_t        encAdjValue,
    output mdep_pos_t        indexShift,
    output logic             persistDirInv,
    output logic             posReady,
    output mdep_pos_t        actualPos
);
    function automatic logic [31:0] rangeSpan(input logic multi);
        rangeSpan = multi ? `MDEP_USR_PER_TURN * `MDEP_ENC_TURNS : `MDEP_USR_PER_TURN;
    endfunction

    function automatic logic [31:0] modRange(input logic [31:0] v, input logic multi);
        modRange = v & (rangeSpan(multi) - 32'h0000_0001);
    endfunction

    // Upper half of a shifted multiturn range reads as negative
    function automatic mdep_pos_t centreRange(input logic [31:0] v, input logic multi,
                                              input logic shf);
        centreRange = mdep_pos_t'(v);
        if (shf && multi && (v >= (rangeSpan(multi) >> 1))) begin
            centreRange = mdep_pos_t'(v - rangeSpan(multi)); // R17
        end
    endfunction

    logic        jogPos;
    logic        jogNeg;
    mdep_state_t state_ff;
    mdep_state_t nxt_state;
    logic        dirInvSet_ff;
    logic        nxt_dirInvSet;
    logic        dirInvAct_ff;
    logic        nxt_dirInvAct;
    logic        shiftAct_ff;
    logic        nxt_shiftAct;
    mdep_pos_t   adjust_ff;
    mdep_pos_t   nxt_adjust;
    logic [31:0] absPos_ff;
    logic [31:0] nxt_absPos;
    mdep_pos_t   actPos_ff;
    mdep_pos_t   nxt_actPos;
    mdep_pos_t   idxShift_ff;
    mdep_pos_t   nxt_idxShift;
    logic        adjStb_ff;
    logic        nxt_adjStb;
    logic [31:0] rdData_ff;
    logic [31:0] nxt_rdData;
    logic        ack_ff;
    logic        nxt_ack;
    logic        err_ff;
    logic        nxt_err;
    mdep_pos_t   motTarget_ff;
    mdep_pos_t   nxt_motTarget;
    logic        motValid_ff;
    logic        nxt_motValid;
    logic        jogAct;
    logic        adjInRange;
    mdep_pos_t   adjLo;
    mdep_pos_t   adjHi;

    mdep_pin_sync u_jog_pos (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .pinIn    (jogPosPin),
        .pinLevel (jogPos)
    );

    mdep_pin_sync u_jog_neg (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .pinIn    (jogNegPin),
        .pinLevel (jogNeg)
    );

    // Jog needs exactly one direction active
    assign jogAct = jogPos ^ jogNeg; // R1

    // Adjustment limits in user units
    always_comb begin
        adjLo = 32'sh0000_0000;
        adjHi = mdep_pos_t'(rangeSpan(encMultiturn) - 32'h0000_0001); // R12 R13
        if (shiftAct_ff) begin
            if (encMultiturn) begin
                adjLo = -mdep_pos_t'(`MDEP_USR_PER_TURN * `MDEP_ENC_HALF_TURNS); // R12 R17
            end else begin
                adjLo = -mdep_pos_t'(`MDEP_USR_PER_TURN >> 1); // R12
            end
            adjHi = -adjLo - 32'sh0000_0001;
        end
        adjInRange = ($signed(parWrData) >= adjLo) && ($signed(parWrData) <= adjHi);
    end

    always_comb begin
        nxt_state     = state_ff;
        nxt_dirInvSet = dirInvSet_ff;
        nxt_dirInvAct = dirInvAct_ff;
        nxt_shiftAct  = shiftAct_ff;
        nxt_adjust    = adjust_ff;
        nxt_absPos    = absPos_ff;
        nxt_actPos    = actPos_ff;
        nxt_idxShift  = idxShift_ff;
        nxt_adjStb    = 1'b0;
        nxt_rdData    = rdData_ff;
        nxt_ack       = 1'b0;
        nxt_err       = 1'b0;
        nxt_motValid  = 1'b0;
        nxt_motTarget = motTarget_ff;

        unique case (state_ff)
            MDEP_ST_BOOT: begin
                // Persisted settings take effect at power-on
                nxt_dirInvSet = bootDirInv; // R3
                nxt_dirInvAct = bootDirInv; // R3
                nxt_shiftAct  = bootShift; // R17
                nxt_state     = MDEP_ST_REQ;
            end
            MDEP_ST_REQ: begin
                nxt_state = MDEP_ST_WAIT; // R4
            end
            MDEP_ST_WAIT: begin
                if (encRdValid) begin
                    // Raw increments to user units, reference from encoder only
                    nxt_absPos = modRange(encRdRaw >> `MDEP_INC_TO_USR_SHIFT,
                                          encMultiturn); // R4 R6 R7
                    nxt_actPos = centreRange(modRange(encRdRaw >> `MDEP_INC_TO_USR_SHIFT,
                                                      encMultiturn), encMultiturn,
                                             shiftAct_ff); // R9 R17
                    nxt_state  = MDEP_ST_RUN;
                end
            end
            MDEP_ST_RUN: begin
                if (encDeltaValid) begin
                    nxt_actPos = actPos_ff + encDelta; // R8
                    nxt_absPos = modRange(absPos_ff + 32'(encDelta), encMultiturn); // R5
                end
                if (cmdValid) begin
                    nxt_motValid  = 1'b1;
                    nxt_motTarget = dirInvAct_ff ? -cmdTarget : cmdTarget; // R2
                end
            end
            default: begin
                nxt_state = MDEP_ST_BOOT;
            end
        endcase

        if (parWrEn || parRdEn) begin
            nxt_ack = 1'b1;
            nxt_err = 1'b1;
            unique case (parAddr)
                `MDEP_ADDR_DIR_INV: begin
                    nxt_err    = 1'b0;
                    nxt_rdData = {31'h0000_0000, dirInvSet_ff};
                    if (parWrEn) begin
                        if (pwrStageOn || (parWrData[31:1] != 31'h0000_0000)) begin
                            nxt_err = 1'b1; // R3
                        end else begin
                            nxt_dirInvSet = parWrData[`MDEP_DIR_INV_BIT]; // R3
                        end
                    end
                end
                `MDEP_ADDR_ENC_ADJUST: begin
                    nxt_err    = 1'b0;
                    nxt_rdData = adjust_ff;
                    if (parWrEn) begin
                        if (!motStandstill || !adjInRange || !state_ff[3]) begin
                            nxt_err = 1'b1; // R10 R12
                        end else begin
                            nxt_adjust   = $signed(parWrData); // R10
                            nxt_idxShift = $signed(parWrData) - mdep_pos_t'(absPos_ff); // R11
                            nxt_adjStb   = 1'b1; // R10
                        end
                    end
                end
                `MDEP_ADDR_ENC_ABS_POS: begin
                    nxt_err    = parWrEn; // R5
                    nxt_rdData = absPos_ff; // R5
                end
                default: begin
                    nxt_rdData = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= MDEP_ST_BOOT;
            dirInvSet_ff <= `MDEP_DIR_INV_RST;
            dirInvAct_ff <= `MDEP_DIR_INV_RST;
            shiftAct_ff  <= `MDEP_SHIFT_OFF;
            adjust_ff    <= `MDEP_ADJUST_RST;
            absPos_ff    <= 32'h0000_0000;
            actPos_ff    <= 32'sh0000_0000;
            idxShift_ff  <= 32'sh0000_0000;
            adjStb_ff    <= 1'b0;
            rdData_ff    <= 32'h0000_0000;
            ack_ff       <= 1'b0;
            err_ff       <= 1'b0;
            motTarget_ff <= 32'sh0000_0000;
            motValid_ff  <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            dirInvSet_ff <= nxt_dirInvSet;
            dirInvAct_ff <= nxt_dirInvAct;
            shiftAct_ff  <= nxt_shiftAct;
            adjust_ff    <= nxt_adjust;
            absPos_ff    <= nxt_absPos;
            actPos_ff    <= nxt_actPos;
            idxShift_ff  <= nxt_idxShift;
            adjStb_ff    <= nxt_adjStb;
            rdData_ff    <= nxt_rdData;
            ack_ff       <= nxt_ack;
            err_ff       <= nxt_err;
            motTarget_ff <= nxt_motTarget;
            motValid_ff  <= nxt_motValid;
        end
    end

    assign pwrStageOn    = hostEnable || (jogAct && state_ff[3]); // R1
    assign jogActive     = jogAct && state_ff[3]; // R1
    assign jogDirNeg     = jogNeg; // R1
    assign encRdReq      = (state_ff == MDEP_ST_REQ); // R4
    assign posReady      = state_ff[3];
    assign parRdData     = rdData_ff;
    assign parAck        = ack_ff;
    assign parErr        = err_ff;
    assign motValid      = motValid_ff;
    assign motTarget     = motTarget_ff;
    assign encAdjStb     = adjStb_ff;
    assign encAdjValue   = adjust_ff;
    assign indexShift    = idxShift_ff;
    assign persistDirInv = dirInvSet_ff;
    assign actualPos     = actPos_ff;
endmodule

`default_nettype wire

/* mdep_motion_position_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mdep_motion_position_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        parWrEn,
    input wire logic        parRdEn,
    input wire logic [15:0] parAddr,
    input wire logic [31:0] parWrData,
    input wire logic        parAck,
    input wire logic        parErr,
    input wire logic        jogActive,
    input wire logic        pwrStageOn,
    input wire logic        motStandstill,
    input wire logic        encRdReq,
    input wire logic        posReady,
    input wire logic        encAdjStb,
    input wire logic [31:0] encAdjValue,
    input wire logic        encDeltaValid,
    input wire logic [31:0] encDelta,
    input wire logic [31:0] actualPos
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ack_follows_a: assert property ((parWrEn || parRdEn) |=> parAck)
        else $error("no answer after request");
    ack_only_req_a: assert property (!(parWrEn || parRdEn) |=> !parAck)
        else $error("answer without request");
    abs_pos_ro_a: assert property (parWrEn && parAddr == 16'h1e1e |=> parErr)
        else $error("write to position accepted");
    inv_pwr_lock_a: assert property (parWrEn && parAddr == 16'h0618 && pwrStageOn |=> parErr)
        else $error("inversion written with power on");
    adj_standstill_a: assert property (parWrEn && parAddr == 16'h052c && !motStandstill
        |=> parErr && !encAdjStb)
        else $error("adjust accepted while moving");
    adj_value_a: assert property (encAdjStb |-> encAdjValue == $past(parWrData) && !parErr)
        else $error("adjust value wrong");
    adj_boot_a: assert property (parWrEn && parAddr == 16'h052c && !posReady |=> parErr)
        else $error("adjust accepted before start-up read");
    jog_power_a: assert property (jogActive |-> pwrStageOn)
        else $error("jog without power stage");
    boot_read_a: assert property (encRdReq |-> !posReady)
        else $error("encoder read after ready");
    pos_count_a: assert property (posReady && encDeltaValid
        |=> actualPos == $past(actualPos) + $past(encDelta))
        else $error("actual position not counted");
endmodule
bind mdep_motion_position mdep_motion_position_checker i_mdep_motion_position_checker (
    .clk_sys, .arst_n, .parWrEn, .parRdEn, .parAddr, .parWrData, .parAck, .parErr,
    .jogActive, .pwrStageOn, .motStandstill, .encRdReq, .posReady, .encAdjStb,
    .encAdjValue, .encDeltaValid, .encDelta, .actualPos);
`default_nettype wire

/* mdep_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mdep_pin_sync (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic pinIn,
    output logic      pinLevel
);
    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;
    logic level_ff;
    logic nxt_level;

    // Level changes only when second and third stages agree
    always_comb begin
        nxt_level = level_ff;
        if (stage2_ff == stage3_ff) begin
            nxt_level = stage3_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
            level_ff  <= 1'b0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            level_ff  <= nxt_level;
        end
    end

    assign pinLevel = level_ff;
endmodule

`default_nettype wire

/* mdep_pkg.sv */
package mdep_pkg;

    typedef enum logic [3:0] {
        MDEP_ST_BOOT = 4'b0001,
        MDEP_ST_REQ  = 4'b0010,
        MDEP_ST_WAIT = 4'b0100,
        MDEP_ST_RUN  = 4'b1000
    } mdep_state_t;

    typedef logic signed [31:0] mdep_pos_t;

endpackage

/* motion_direction_encoder_position_test.sv */
`timescale 1ns/1ps
`default_nettype none
module motion_direction_encoder_position_test
    import mdep_pkg::*;
;
    logic clk_sys = 0, arst_n = 0, parWrEn = 0, parRdEn = 0, jogPosPin = 0, jogNegPin = 0;
    logic hostEnable = 0, motStandstill = 1, cmdValid = 0, bootDirInv = 0, bootShift = 0;
    logic encMultiturn = 1, encDeltaValid = 0;
    logic [15:0] parAddr = 16'h0000;
    logic [31:0] parWrData = 32'h0, rawPos = 32'h0001_0040, parRdData, encRdRaw, d, ex;
    mdep_pos_t cmdTarget = 32'h0, encDelta = 32'h0, motTarget, encAdjValue, indexShift, actualPos;
    logic parAck, parErr, pwrStageOn, jogActive, jogDirNeg, motValid, encRdReq, encRdValid;
    logic encAdjStb, persistDirInv, posReady;
    int err_total = 0, n_checks = 0, seed = 32'hbe9eabf6;
    logic [33:0] q[$];
    logic [33:0] e;
    mdep_motion_position i_mdep_motion_position (.clk_sys, .arst_n, .parWrEn, .parRdEn,
        .parAddr, .parWrData, .parRdData, .parAck, .parErr, .jogPosPin, .jogNegPin,
        .hostEnable, .motStandstill, .pwrStageOn, .jogActive, .jogDirNeg, .cmdValid,
        .cmdTarget, .motValid, .motTarget, .bootDirInv, .bootShift, .encMultiturn, .encRdReq,
        .encRdValid, .encRdRaw, .encDeltaValid, .encDelta, .encAdjStb, .encAdjValue,
        .indexShift, .persistDirInv, .posReady, .actualPos);
    mdep_enc_model i_mdep_enc_model (.clk_sys, .arst_n, .encRdReq, .rawPos, .encRdValid,
        .encRdRaw);
    always #2 clk_sys = ~clk_sys;
    task automatic chk(string nm, logic [31:0] ev, logic [31:0] sv);
        n_checks++;
        if (sv !== ev) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, ev, sv);
        end
    endtask
    task automatic acc(logic wr, logic [15:0] a, logic [31:0] dt, logic ee, logic cd,
        logic [31:0] ed);
        @(negedge clk_sys);
        parWrEn = wr; parRdEn = !wr; parAddr = a; parWrData = dt;
        q.push_back({cd, ee, ed});
        @(negedge clk_sys);
        parWrEn = 0; parRdEn = 0;
    endtask
    task automatic rst(logic inv, logic shf, logic mt, logic [31:0] ea);
        arst_n = 0; bootDirInv = inv; bootShift = shf; encMultiturn = mt;
        repeat (6) @(negedge clk_sys);
        arst_n = 1;
        acc(1, 16'h052c, 32'h0000_0010, 1, 0, 32'h0);
        for (int i = 0; i < 50 && posReady !== 1'b1; i++) @(negedge clk_sys);
        chk("ready", 32'h1, 32'(posReady));
        chk("actual", ea, actualPos);
    endtask
    task automatic cmd(logic [31:0] t, logic [31:0] ev);
        @(negedge clk_sys);
        cmdValid = 1; cmdTarget = t;
        @(negedge clk_sys);
        cmdValid = 0;
        chk("motValid", 32'h1, 32'(motValid));
        chk("motTarget", ev, motTarget);
    endtask
    task automatic jog(logic p, logic n, logic ea, logic en);
        jogPosPin = p; jogNegPin = n;
        repeat (8) @(negedge clk_sys);
        chk("jogActive", 32'(ea), 32'(jogActive));
        chk("pwrStageOn", 32'(ea), 32'(pwrStageOn));
        if (ea) chk("jogDirNeg", 32'(en), 32'(jogDirNeg));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk_sys) begin
        if (parAck === 1'b1) begin
            if (q.size() == 0) chk("ack", 32'h0, 32'h1);
            else begin
                e = q.pop_front();
                chk("parErr", 32'(e[32]), 32'(parErr));
                if (e[33]) chk("parRdData", e[31:0], parRdData);
            end
        end
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        rst(0, 0, 1, 32'h0000_2008);
        acc(0, 16'h1e1e, 32'h0, 0, 1, 32'h0000_2008);
        acc(0, 16'h0618, 32'h0, 0, 1, 32'h0);
        acc(0, 16'h0100, 32'h0, 1, 1, 32'h0);
        acc(1, 16'h1e1e, 32'h5, 1, 0, 32'h0);
        motStandstill = 0;
        acc(1, 16'h052c, 32'h7, 1, 0, 32'h0);
        motStandstill = 1;
        acc(1, 16'h052c, 32'h0400_0000, 1, 0, 32'h0);
        acc(1, 16'h052c, 32'h03ff_ffff, 0, 0, 32'h0);
        chk("adjStb", 32'h1, 32'(encAdjStb));
        chk("adjValue", 32'h03ff_ffff, encAdjValue);
        chk("indexShift", 32'h03ff_ffff - 32'h0000_2008, indexShift);
        acc(0, 16'h052c, 32'h0, 0, 1, 32'h03ff_ffff);
        @(negedge clk_sys);
        encDeltaValid = 1; encDelta = 32'hffff_dff3;
        @(negedge clk_sys);
        encDeltaValid = 0;
        chk("actual", 32'hffff_fffb, actualPos);
        acc(0, 16'h1e1e, 32'h0, 0, 1, 32'h03ff_fffb);
        ex = 32'h0;
        for (int i = 0; i < 8; i++) begin
            d = 32'($random(seed)) & 32'h3;
            if (d < 32'h2) ex = d;
            acc(1, 16'h0618, d, d > 32'h1, 0, 32'h0);
            acc(0, 16'h0618, 32'h0, 0, 1, ex);
            chk("persist", ex, 32'(persistDirInv));
        end
        hostEnable = 1;
        acc(1, 16'h0618, 32'h0, 1, 0, 32'h0);
        hostEnable = 0;
        acc(1, 16'h0618, 32'h1, 0, 0, 32'h0);
        cmd(32'h0000_0064, 32'h0000_0064);
        jog(1, 0, 1, 0);
        jog(0, 1, 1, 1);
        jog(1, 1, 0, 0);
        jog(0, 0, 0, 0);
        rst(1, 1, 0, 32'h0000_2008);
        cmd(32'h0000_0064, 32'hffff_ff9c);
        cmd(32'hffff_ff9c, 32'h0000_0064);
        acc(1, 16'h052c, 32'hffff_e000, 0, 0, 32'h0);
        acc(1, 16'h052c, 32'h0000_2000, 1, 0, 32'h0);
        acc(1, 16'h052c, 32'hffff_dfff, 1, 0, 32'h0);
        rawPos = 32'hffff_fff8;
        rst(0, 1, 1, 32'hffff_ffff);
        acc(0, 16'h1e1e, 32'h0, 0, 1, 32'h03ff_ffff);
        acc(1, 16'h052c, 32'hfe00_0000, 0, 0, 32'h0);
        acc(1, 16'h052c, 32'h0200_0000, 1, 0, 32'h0);
        repeat (2) @(negedge clk_sys);
        tally_and_finish();
    end
endmodule
`default_nettype wire
